// ===== core/ffo_host.sv
// Host end: APB registers turn commands into pin sequences toward the device.
// Assumes the device samples its pins on the same pclk edges.
`timescale 1ns/1ps
module ffo_host
  import ffo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  ffo_if.host link
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  ffo_hstate_t state;
  logic [4:0] cnt;
  logic [DATA_W-1:0] wdata;
  logic [SER_BITS-1:0] ser;
  logic [SER_BITS-1:0] shreg;
  logic [DATA_W-1:0] rdata;
  logic [1:0] cfg;
  logic [IRQ_W-1:0] irq_st;
  logic [IRQ_W-1:0] mask;
  logic is_read;
  logic paf_d;
  logic pae_d;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire busy = (state != H_IDLE);
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= A_CFG);
  wire go = wr && (paddr == A_CMD) && !busy;
  wire [2:0] cmd = pwdata[2:0];
  wire [IRQ_W-1:0] ev;
  wire [IRQ_W-1:0] clr = (psel && !penable && !pwrite && paddr == A_IRQ) ? '1 : '0;
  wire [5:0] pins = {busy, link.almost_full_flag_n, link.almost_empty_flag_n,
                     link.half_full_flag_n, link.full_flag_n, link.empty_flag_n};

  assign ev[I_DONE] = (state == H_CAPT);
  assign ev[I_AF] = paf_d && !link.almost_full_flag_n;
  assign ev[I_AE] = pae_d && !link.almost_empty_flag_n;
  assign pready = acc;
  assign pslverr = acc && !mapped;
  assign irq = |(irq_st & mask);

  ////////////////////////////////////////////////////////////////////////////
  // APB register side

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata <= '0;
      ser <= '0;
      cfg <= '0;
      mask <= '0;
    end else if (wr) begin
      if (paddr == A_WDATA) wdata <= pwdata[DATA_W-1:0];
      if (paddr == A_SER) ser <= pwdata[SER_BITS-1:0];
      if (paddr == A_CFG) cfg <= pwdata[1:0];
      if (paddr == A_MASK) mask <= pwdata[IRQ_W-1:0];
    end
  end

  // Read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        A_WDATA: prdata <= {14'h0000, wdata};
        A_SER: prdata <= {6'h00, ser};
        A_RDATA: prdata <= {14'h0000, rdata};
        A_FLAGS: prdata <= {26'h0000000, pins};
        A_IRQ: prdata <= {29'h00000000, irq_st};
        A_MASK: prdata <= {29'h00000000, mask};
        A_CFG: prdata <= {30'h00000000, cfg};
        default: prdata <= '0;
      endcase
    end
  end

  // Sticky status: set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st <= '0;
      paf_d <= 1'b1;
      pae_d <= 1'b0;
    end else begin
      irq_st <= (irq_st & ~clr) | ev;
      paf_d <= link.almost_full_flag_n;
      pae_d <= link.almost_empty_flag_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= H_IDLE;
      cnt <= '0;
      shreg <= '0;
      rdata <= '0;
      is_read <= 1'b0;
      link.mrs_n <= 1'b1;
      link.prs_n <= 1'b1;
      link.load_select_n <= 1'b1;
      link.wen_n <= 1'b1;
      link.ren_n <= 1'b1;
      link.serial_load_enable_n <= 1'b1;
      link.fall_through_select_serial_in <= 1'b0;
      link.d <= '0;
    end else begin
      case (state)
        H_IDLE: begin
          if (go) begin
            is_read <= (cmd == C_ORD) || (cmd == C_MRD);
            link.d <= wdata;
            state <= H_DRIVE;
            case (cmd)
              C_MRS: begin
                // [RULE_01] load strap held through reset
                // [RULE_15] timing strap held through reset
                link.mrs_n <= 1'b0;
                link.load_select_n <= cfg[0];
                link.fall_through_select_serial_in <= cfg[1];
                cnt <= 5'(RST_CYC - 1);
                state <= H_RST;
              end
              C_PRS: begin
                link.prs_n <= 1'b0;
                cnt <= 5'(RST_CYC - 1);
                state <= H_RST;
              end
              // [RULE_10] offset write pattern
              C_OWR: begin
                link.load_select_n <= 1'b0;
                link.wen_n <= 1'b0;
              end
              // [RULE_11] offset read pattern
              C_ORD: begin
                link.load_select_n <= 1'b0;
                link.ren_n <= 1'b0;
              end
              // [RULE_13] first bit is empty offset LSB
              C_SER: begin
                link.load_select_n <= 1'b0;
                link.serial_load_enable_n <= 1'b0;
                link.fall_through_select_serial_in <= ser[0];
                shreg <= ser >> 1;
                cnt <= 5'(SER_BITS - 1);
                state <= H_SHIFT;
              end
              C_MWR: link.wen_n <= 1'b0;
              C_MRD: link.ren_n <= 1'b0;
              default: state <= H_IDLE;
            endcase
          end
        end
        H_RST: begin
          if (cnt == 5'h00) begin
            link.mrs_n <= 1'b1;
            link.prs_n <= 1'b1;
            link.load_select_n <= 1'b1;
            link.fall_through_select_serial_in <= 1'b0;
            state <= H_CAPT;
          end else begin
            cnt <= 5'(cnt - 5'h01);
          end
        end
        H_SHIFT: begin
          if (cnt == 5'h00) begin
            link.load_select_n <= 1'b1;
            link.serial_load_enable_n <= 1'b1;
            link.fall_through_select_serial_in <= 1'b0;
            state <= H_CAPT;
          end else begin
            // [RULE_12] one bit per clock
            link.fall_through_select_serial_in <= shreg[0];
            shreg <= shreg >> 1;
            cnt <= 5'(cnt - 5'h01);
          end
        end
        H_DRIVE: begin
          link.load_select_n <= 1'b1;
          link.wen_n <= 1'b1;
          link.ren_n <= 1'b1;
          state <= H_CAPT;
        end
        H_CAPT: begin
          if (is_read) rdata <= link.q;
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule // ffo_host

// ===== core/ffo_pkg.sv
// Constants shared by both ends of the flag offset link and the flag generator.
// Assumes one clock, pclk at 250 MHz, for both ends.
package ffo_pkg;

  localparam int DATA_W = 18;
  localparam int OFS_W = 13;
  localparam int CNT_W = 14;
  localparam int SER_BITS = 26;
  localparam int SER_CW = 5;

  // Word counts
  localparam logic [CNT_W-1:0] CAP_STD = 14'h2000;
  localparam logic [CNT_W-1:0] CAP_FT = 14'h2001;
  localparam logic [CNT_W-1:0] HALF_STD = 14'h1001;
  localparam logic [CNT_W-1:0] HALF_FT = 14'h1002;

  // Offset defaults
  localparam logic [OFS_W-1:0] OFS_SER_DEF = 13'h03FF;
  localparam logic [OFS_W-1:0] OFS_PAR_DEF = 13'h007F;

  // Master/partial reset pulse width
  localparam int CLK_PS = 4000;
  localparam int RST_NS = 10;
  localparam int RST_CYC = (RST_NS * 1000 + CLK_PS - 1) / CLK_PS;

  // Host register offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_WDATA = 8'h04;
  localparam logic [7:0] A_SER = 8'h08;
  localparam logic [7:0] A_RDATA = 8'h0C;
  localparam logic [7:0] A_FLAGS = 8'h10;
  localparam logic [7:0] A_IRQ = 8'h14;
  localparam logic [7:0] A_MASK = 8'h18;
  localparam logic [7:0] A_CFG = 8'h1C;

  // Host commands
  localparam logic [2:0] C_MRS = 3'h1;
  localparam logic [2:0] C_PRS = 3'h2;
  localparam logic [2:0] C_OWR = 3'h3;
  localparam logic [2:0] C_ORD = 3'h4;
  localparam logic [2:0] C_SER = 3'h5;
  localparam logic [2:0] C_MWR = 3'h6;
  localparam logic [2:0] C_MRD = 3'h7;

  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int I_DONE = 0;
  localparam int I_AF = 1;
  localparam int I_AE = 2;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_RST = 3'b001,
    H_DRIVE = 3'b010,
    H_SHIFT = 3'b011,
    H_CAPT = 3'b100
  } ffo_hstate_t;

endpackage

// ===== core/ffo_if.sv
// Pins between the host logic and the flag offset device.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface ffo_if;
  import ffo_pkg::*;
  logic mrs_n;
  logic prs_n;
  logic load_select_n;
  logic wen_n;
  logic ren_n;
  logic serial_load_enable_n;
  logic fall_through_select_serial_in;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] q;
  logic empty_flag_n;
  logic full_flag_n;
  logic almost_empty_flag_n;
  logic almost_full_flag_n;
  logic half_full_flag_n;

  modport dev (
    input mrs_n, prs_n, load_select_n, wen_n, ren_n, serial_load_enable_n,
    input fall_through_select_serial_in, d,
    output q, empty_flag_n, full_flag_n, almost_empty_flag_n,
    output almost_full_flag_n, half_full_flag_n
  );

  modport host (
    output mrs_n, prs_n, load_select_n, wen_n, ren_n, serial_load_enable_n,
    output fall_through_select_serial_in, d,
    input q, empty_flag_n, full_flag_n, almost_empty_flag_n,
    input almost_full_flag_n, half_full_flag_n
  );
endinterface

// ===== core/ffo_flag_gen.sv
// Combinational status flags from word count and offsets.
// Assumes count never exceeds the capacity of the selected mode.
`timescale 1ns/1ps
module ffo_flag_gen
  import ffo_pkg::*;
(
  input wire logic fall_through_mode,
  input wire logic [CNT_W-1:0] count,
  input wire logic [OFS_W-1:0] ofs_e,
  input wire logic [OFS_W-1:0] ofs_f,
  output logic ef_n,
  output logic ff_n,
  output logic pae_n,
  output logic hf_n,
  output logic paf_n
);
  wire [CNT_W-1:0] cap = fall_through_mode ? CAP_FT : CAP_STD;
  wire [CNT_W-1:0] n_ext = {1'b0, ofs_e};
  wire [CNT_W-1:0] ae_thr = fall_through_mode ? CNT_W'(n_ext + 14'h0001) : n_ext;
  wire [CNT_W-1:0] af_thr = CNT_W'(cap - {1'b0, ofs_f});
  wire [CNT_W-1:0] hf_thr = fall_through_mode ? HALF_FT : HALF_STD;

  // [RULE_06] standard empty and full
  // [RULE_08] fall-through ready pins
  assign ef_n = fall_through_mode ? (count == 14'h0000) : (count != 14'h0000);
  assign ff_n = fall_through_mode ? (count == cap) : (count != cap);
  // [RULE_07] standard partial flags
  // [RULE_09] fall-through partial flags
  assign pae_n = count > ae_thr;
  assign hf_n = count < hf_thr;
  assign paf_n = count < af_thr;
endmodule // ffo_flag_gen

// ===== core/ffo_device.sv
// Flag offset registers, offset programming and status flags of the FIFO.
// Assumes the host drives the pins synchronous to pclk; one pclk edge stands
// for one write-clock and one read-clock edge.
//
// What this block does
// [RULE_01] Load pin latched only at master reset
// [RULE_02] Serial selection presets both offsets to 3FF
// [RULE_03] Parallel selection presets both offsets to 07F
// [RULE_04] Offsets read back in parallel, any method
// [RULE_05] Offsets reprogrammable any time after reset
// [RULE_06] Standard empty and full flag levels
// [RULE_07] Standard almost-empty, half, almost-full thresholds
// [RULE_08] Fall-through output-ready and input-ready levels
// [RULE_09] Fall-through partial flag thresholds, shifted one
// [RULE_10] Parallel offset write, empty then full
// [RULE_11] Parallel offset read, empty then full
// [RULE_12] Serial shift one bit per edge, 26 bits
// [RULE_13] Serial order empty LSB to full MSB
// [RULE_14] Same control encoding in both timing modes
// [RULE_15] Timing mode sampled at master reset
// [RULE_16] Offset pointers alternate empty and full
// [RULE_17] Master reset homes pointers, partial keeps
// [RULE_18] Memory access with load high, else idle
`timescale 1ns/1ps
module ffo_device
  import ffo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  ffo_if.dev link,
  output logic serial_mode,
  output logic fall_through_mode_mode,
  output logic [CNT_W-1:0] word_count,
  output logic [OFS_W-1:0] empty_offset,
  output logic [OFS_W-1:0] full_offset,
  output logic offsets_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode

  logic wptr;
  logic rptr;
  logic [SER_CW-1:0] ser_cnt;
  logic [DATA_W-1:0] q_reg;

  wire mrs = !link.mrs_n;
  wire prs = !link.prs_n;
  wire ld_n = link.load_select_n;
  wire we_n = link.wen_n;
  wire re_n = link.ren_n;
  wire sen_n = link.serial_load_enable_n;
  wire si = link.fall_through_select_serial_in;
  wire any_rst = mrs | prs;

  // [RULE_14] one decode for both timing modes
  // [RULE_10] parallel write encoding
  wire op_owr = !ld_n && !we_n && re_n && sen_n && !serial_mode && !any_rst;
  // [RULE_11] parallel read encoding
  // [RULE_04] readback allowed in either method
  wire op_ord = !ld_n && we_n && !re_n && sen_n && !any_rst;
  // [RULE_12] serial shift encoding
  wire op_ser = !ld_n && we_n && re_n && !sen_n && serial_mode && !any_rst;

  // [RULE_18] memory access only with load high
  wire [CNT_W-1:0] cap = fall_through_mode_mode ? CAP_FT : CAP_STD;
  wire mem_wr = ld_n && !we_n && (word_count != cap) && !any_rst;
  wire mem_rd = ld_n && !re_n && (word_count != 14'h0000) && !any_rst;

  // [RULE_13] new bit enters at full MSB, first bit ends at empty LSB
  wire [2*OFS_W-1:0] ser_next = {si, full_offset, empty_offset[OFS_W-1:1]};

  wire [OFS_W-1:0] rd_sel = rptr ? full_offset : empty_offset;
  wire [CNT_W-1:0] next_count =
    CNT_W'(word_count + {13'h0000, mem_wr} - {13'h0000, mem_rd});
  wire ser_last = (ser_cnt == SER_CW'(SER_BITS - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Mode straps

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode <= 1'b0;
      fall_through_mode_mode <= 1'b0;
    end else if (mrs) begin
      // [RULE_01] load method caught only in master reset
      serial_mode <= ld_n;
      // [RULE_15] timing mode caught in master reset
      fall_through_mode_mode <= si;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_offset <= OFS_PAR_DEF;
      full_offset <= OFS_PAR_DEF;
    end else if (mrs) begin
      // [RULE_02] serial defaults
      // [RULE_03] parallel defaults
      empty_offset <= ld_n ? OFS_SER_DEF : OFS_PAR_DEF;
      full_offset <= ld_n ? OFS_SER_DEF : OFS_PAR_DEF;
    end else if (op_owr) begin
      // [RULE_05] reprogramming at any time
      if (!wptr) begin
        empty_offset <= link.d[OFS_W-1:0];
      end else begin
        full_offset <= link.d[OFS_W-1:0];
      end
    end else if (op_ser) begin
      // [RULE_12] one bit per edge
      {full_offset, empty_offset} <= ser_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset pointers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= 1'b0;
    end else if (mrs) begin
      // [RULE_17] master reset homes write pointer
      wptr <= 1'b0;
    end else if (op_owr) begin
      // [RULE_16] alternate write target
      wptr <= !wptr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr <= 1'b0;
    end else if (mrs) begin
      // [RULE_17] master reset homes read pointer
      rptr <= 1'b0;
    end else if (op_ord) begin
      // [RULE_16] alternate read source
      rptr <= !rptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial progress

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_cnt <= '0;
    end else if (mrs) begin
      ser_cnt <= '0;
    end else if (op_ser) begin
      ser_cnt <= ser_last ? '0 : SER_CW'(ser_cnt + 5'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offsets_valid <= 1'b1;
    end else if (mrs) begin
      offsets_valid <= 1'b1;
    end else if (op_ser) begin
      offsets_valid <= ser_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset readback onto data outputs

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= '0;
    end else if (op_ord) begin
      // [RULE_11] empty then full on read edges
      q_reg <= {{(DATA_W - OFS_W){1'b0}}, rd_sel};
    end
  end

  assign link.q = q_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Word count

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_count <= '0;
    end else if (any_rst) begin
      word_count <= '0;
    end else begin
      // [RULE_18] memory write and read
      word_count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  logic c_ef_n;
  logic c_ff_n;
  logic c_pae_n;
  logic c_hf_n;
  logic c_paf_n;
  logic ef_s1;
  logic ff_s1;
  logic ef_s2;
  logic ff_s2;
  logic pae_r;
  logic hf_r;
  logic paf_r;

  ffo_flag_gen u_flags (
    .fall_through_mode(fall_through_mode_mode),
    .count(word_count),
    .ofs_e(empty_offset),
    .ofs_f(full_offset),
    .ef_n(c_ef_n),
    .ff_n(c_ff_n),
    .pae_n(c_pae_n),
    .hf_n(c_hf_n),
    .paf_n(c_paf_n)
  );

  // Empty and full pins are double registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ef_s1 <= 1'b0;
      ff_s1 <= 1'b1;
      ef_s2 <= 1'b0;
      ff_s2 <= 1'b1;
    end else begin
      ef_s1 <= c_ef_n;
      ff_s1 <= c_ff_n;
      ef_s2 <= ef_s1;
      ff_s2 <= ff_s1;
    end
  end

  // Almost-empty and almost-full flags held inactive while a serial load is incomplete; half flag not held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pae_r <= 1'b0;
      hf_r <= 1'b1;
      paf_r <= 1'b1;
    end else begin
      pae_r <= offsets_valid ? c_pae_n : 1'b1;
      hf_r <= c_hf_n;
      paf_r <= offsets_valid ? c_paf_n : 1'b1;
    end
  end

  // [RULE_06] empty and full outputs
  // [RULE_08] output-ready and input-ready on the same pins
  assign link.empty_flag_n = ef_s2;
  assign link.full_flag_n = ff_s2;
  // [RULE_07] partial flag outputs
  // [RULE_09] same pins in fall-through mode
  assign link.almost_empty_flag_n = pae_r;
  assign link.half_full_flag_n = hf_r;
  assign link.almost_full_flag_n = paf_r;

endmodule // ffo_device

// ===== sim/ffo_checker.sv
// Pin checks between the host end and the device end of the flag offset link.
// Assumes the ffo_if signals and the bench clock and reset as plain inputs.
`timescale 1ns/1ps
module ffo_checker
  import ffo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mrs_n,
  input wire logic prs_n,
  input wire logic load_select_n,
  input wire logic wen_n,
  input wire logic ren_n,
  input wire logic serial_load_enable_n,
  input wire logic fall_through_select_serial_in,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic half_full_flag_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Word count and timing mode as the pins imply
  logic ft;
  logic [CNT_W-1:0] cnt;
  logic [5:0] sh_cnt;
  wire logic [CNT_W-1:0] cap = ft ? CAP_FT : CAP_STD;
  wire logic mem_wr = load_select_n && !wen_n && (cnt != cap);
  wire logic mem_rd = load_select_n && !ren_n && (cnt != '0);
  wire logic [CNT_W-1:0] next_cnt = cnt + CNT_W'(mem_wr) - CNT_W'(mem_rd);
  wire logic shifting = !load_select_n && !serial_load_enable_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft <= 1'b0;
      cnt <= '0;
      sh_cnt <= 6'h00;
    end else begin
      if (!mrs_n) begin
        ft <= fall_through_select_serial_in;
      end
      cnt <= (!mrs_n || !prs_n) ? '0 : next_cnt;
      sh_cnt <= shifting ? sh_cnt + 6'h01 : 6'h00;
    end
  end
  ////////////////////////////////////////
  sequence mrs_pulse;
    !mrs_n [*3] ##1 mrs_n;
  endsequence
  mrs_width_a: assert property ($fell(mrs_n) |-> mrs_pulse)
    else $error("master reset pulse not three cycles");
  ofs_write_code_a: assert property (!load_select_n && !wen_n |-> ren_n && serial_load_enable_n)
    else $error("offset write with other enables active");
  ofs_read_code_a: assert property (!load_select_n && !ren_n |-> wen_n && serial_load_enable_n)
    else $error("offset read with other enables active");
  serial_length_a: assert property ($fell(shifting) |-> sh_cnt == 6'h1A)
    else $error("serial load not 26 bits");
  std_empty_a: assert property ((!ft && cnt == '0 && mrs_n) [*5] |-> !empty_flag_n)
    else $error("empty flag high with no words");
  std_not_empty_a: assert property ((!ft && cnt != '0) [*5] |-> empty_flag_n)
    else $error("empty flag low with words stored");
  std_full_a: assert property ((!ft && cnt != CAP_STD && mrs_n) [*5] |-> full_flag_n)
    else $error("full flag low below depth");
  ft_ready_a: assert property ((ft && cnt == '0 && mrs_n) [*5] |-> empty_flag_n)
    else $error("output ready low when empty");
  ft_stored_a: assert property ((ft && cnt != '0) [*5] |-> !empty_flag_n)
    else $error("output ready high with words stored");
  ft_input_a: assert property ((ft && cnt != CAP_FT && mrs_n) [*5] |-> !full_flag_n)
    else $error("input ready high below capacity");
  half_low_a: assert property ((cnt < HALF_STD && mrs_n) [*5] |-> half_full_flag_n)
    else $error("half flag low below half");
  ae_zero_a: assert property ((cnt == '0 && mrs_n && serial_load_enable_n) [*5]
    |-> !almost_empty_flag_n)
    else $error("almost empty high with no words");
endmodule // ffo_checker

// ===== sim/fifo_flag_offset_programming_tb.sv
// Bench for the flag offset link: APB host end and device end joined by ffo_if.
// Assumes the host register map and command codes of ffo_pkg.
`timescale 1ns/1ps
`define CHK(n, e, g) check_val(n, 32'(e), 32'(g))
module fifo_flag_offset_programming_tb;
  import ffo_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic serial_mode;
  logic fall_through_mode_mode;
  logic [CNT_W-1:0] word_count;
  logic [OFS_W-1:0] empty_offset;
  logic [OFS_W-1:0] full_offset;
  logic [31:0] rd;
  logic perr;
  logic irq_m0;
  logic [12:0] ofs_tab [3] = '{13'h0005, 13'h0009, 13'h0011};
  int errors;
  int check_count;
  ////////////////////////////////////////
  ffo_if u_ffo_if ();
  ffo_host u_ffo_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(u_ffo_if));
  ffo_device u_ffo_device (.pclk(pclk), .presetn(presetn), .link(u_ffo_if),
    .serial_mode(serial_mode), .fall_through_mode_mode(fall_through_mode_mode), .word_count(word_count),
    .empty_offset(empty_offset), .full_offset(full_offset), .offsets_valid());
  ffo_checker u_ffo_checker (.pclk(pclk), .presetn(presetn), .mrs_n(u_ffo_if.mrs_n),
    .prs_n(u_ffo_if.prs_n), .load_select_n(u_ffo_if.load_select_n),
    .wen_n(u_ffo_if.wen_n), .ren_n(u_ffo_if.ren_n),
    .serial_load_enable_n(u_ffo_if.serial_load_enable_n),
    .fall_through_select_serial_in(u_ffo_if.fall_through_select_serial_in),
    .empty_flag_n(u_ffo_if.empty_flag_n), .full_flag_n(u_ffo_if.full_flag_n),
    .almost_empty_flag_n(u_ffo_if.almost_empty_flag_n),
    .half_full_flag_n(u_ffo_if.half_full_flag_n));
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", n, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c);
    apb(1'b1, A_CMD, {29'h0, c});
    rd = 32'h20;
    while (rd[5] !== 1'b0) apb(1'b0, A_FLAGS, 32'h0);
  endtask
  task automatic get_flags();
    repeat (3) @(posedge pclk);
    apb(1'b0, A_FLAGS, 32'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge pclk);
    errors++;
    $display("unexpected run length: expected end, seen hang");
    give_verdict();
  end
  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, A_CFG, 32'h0);
    cmd(C_MRS);
    `CHK("serial mode", 1'b0, serial_mode);
    `CHK("fall_through_mode mode", 1'b0, fall_through_mode_mode);
    `CHK("empty offset", OFS_PAR_DEF, empty_offset);
    `CHK("full offset", OFS_PAR_DEF, full_offset);
    get_flags();
    `CHK("flags", 6'h16, rd[5:0]);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped error", 1'b1, perr);
    `CHK("unmapped data", 32'h0, rd);
    apb(1'b0, A_IRQ, 32'h0);
    `CHK("irq status", 3'h1, rd[2:0]);
    $display("test parallel reset done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, A_WDATA, {19'h0, ofs_tab[i]});
      cmd(C_OWR);
    end
    `CHK("empty offset", 13'h0011, empty_offset);
    `CHK("full offset", 13'h0009, full_offset);
    for (int i = 0; i < 3; i++) begin
      cmd(C_ORD);
      apb(1'b0, A_RDATA, 32'h0);
      `CHK("offset read", (i == 1) ? 13'h0009 : 13'h0011, rd);
    end
    $display("test offset pointers done");
    for (int i = 1; i <= 18; i++) begin
      cmd(C_MWR);
      get_flags();
      `CHK("word count", i, word_count);
      `CHK("empty flag", 1'b1, rd[0]);
      `CHK("almost empty", i >= 18, rd[3]);
    end
    for (int i = 17; i >= -1; i--) begin
      cmd(C_MRD);
      get_flags();
      `CHK("word count", (i < 0) ? 0 : i, word_count);
    end
    `CHK("empty flag", 1'b0, rd[0]);
    apb(1'b0, A_IRQ, 32'h0);
    `CHK("irq status", 3'h5, rd[2:0]);
    cmd(C_MWR);
    cmd(C_PRS);
    `CHK("word count", 0, word_count);
    `CHK("empty offset", 13'h0011, empty_offset);
    cmd(C_ORD);
    apb(1'b0, A_RDATA, 32'h0);
    `CHK("offset read", 13'h0009, rd);
    apb(1'b1, A_MASK, 32'h0);
    @(posedge pclk);
    irq_m0 = irq;
    apb(1'b1, A_MASK, 32'h7);
    @(posedge pclk);
    `CHK("irq masked", 1'b0, irq_m0);
    `CHK("irq unmasked", 1'b1, irq);
    apb(1'b0, A_IRQ, 32'h0);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq);
    $display("test memory flags done");
    apb(1'b1, A_CFG, 32'h1);
    cmd(C_MRS);
    `CHK("serial mode", 1'b1, serial_mode);
    `CHK("empty offset", OFS_SER_DEF, empty_offset);
    `CHK("full offset", OFS_SER_DEF, full_offset);
    apb(1'b1, A_WDATA, 32'h5);
    cmd(C_OWR);
    `CHK("empty offset", OFS_SER_DEF, empty_offset);
    apb(1'b1, A_SER, {6'h00, 13'h0ABC, 13'h0123});
    cmd(C_SER);
    `CHK("empty offset", 13'h0123, empty_offset);
    `CHK("full offset", 13'h0ABC, full_offset);
    cmd(C_ORD);
    apb(1'b0, A_RDATA, 32'h0);
    `CHK("offset read", 13'h0123, rd);
    $display("test serial load done");
    apb(1'b1, A_CFG, 32'h2);
    cmd(C_MRS);
    `CHK("fall_through_mode mode", 1'b1, fall_through_mode_mode);
    get_flags();
    `CHK("ready flags", 2'b01, rd[1:0]);
    apb(1'b1, A_WDATA, 32'h2);
    cmd(C_OWR);
    apb(1'b1, A_WDATA, 32'h1FFE);
    cmd(C_OWR);
    `CHK("empty offset", 13'h0002, empty_offset);
    cmd(C_ORD);
    apb(1'b0, A_RDATA, 32'h0);
    `CHK("offset read", 13'h0002, rd);
    for (int i = 1; i <= 4; i++) begin
      cmd(C_MWR);
      get_flags();
      `CHK("ready flags", 2'b00, rd[1:0]);
      `CHK("almost empty", i >= 4, rd[3]);
      `CHK("almost full", i < 3, rd[4]);
    end
    $display("test fall through done");
    give_verdict();
  end
endmodule // fifo_flag_offset_programming_tb
